/* logic/cis_pkg.sv */
// Constants and types for the two-wire control slave.
// Assumes nothing beyond a SystemVerilog compiler.
package cis_pkg;
    localparam logic [6:0] CIS_ADDR_BASE    = 7'h18;
    localparam logic [1:0] CIS_ADDR_CFG_RST = 2'h2;
    localparam logic       CIS_MODE_PAGE    = 1'h0;
    localparam logic       CIS_MODE_REPEAT  = 1'h1;
    localparam int         CIS_MAP_DEPTH    = 256;
    localparam logic [7:0] CIS_MAP_LAST     = 8'hff;
    localparam logic [7:0] CIS_MAP_RST      = 8'h00;
    localparam logic [7:0] CIS_READ_ZERO    = 8'h00;
    localparam logic [2:0] CIS_BIT_LAST     = 3'h7;
    localparam logic [2:0] CIS_BIT_FIRST    = 3'h0;
    localparam logic       CIS_RW_READ      = 1'h1;
    localparam int         CIS_CLK_MHZ      = 100;
    localparam int         CIS_HS_KHZ       = 3400;

    typedef enum logic [2:0] {
        CIS_IDLE,
        CIS_RX,
        CIS_RX_ACK,
        CIS_TX,
        CIS_TX_ACK,
        CIS_IGNORE
    } cis_state_e;

    typedef enum logic [1:0] {
        CIS_BYTE_DEV,
        CIS_BYTE_REG,
        CIS_BYTE_DATA
    } cis_byte_e;
endpackage

/* logic/cis_sync.sv */
// Three-flop synchroniser for the bus pins: level from the second flop, edges from the second and third.
// Assumes raw pin levels from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module cis_sync
    import cis_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      lvl_o,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } cis_sync_s;

    cis_sync_s st_r;
    cis_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_o  = st_r.s2;
    assign rise_o = st_r.s2 & ~st_r.s3;
    assign fall_o = ~st_r.s2 & st_r.s3;
endmodule
`default_nettype wire

/* logic/cis_slave.sv */
// Two-wire control port slave with a byte-wide register map.
// Assumes external pull-ups; the host is bus master and clocks every bit.
`timescale 1ns/1ns
`default_nettype none
module cis_slave
    import cis_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [1:0] addr_cfg_i,
    input  wire logic       write_mode_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [7:0]      reg_addr_o,
    output logic            wr_pulse_o,
    output logic [7:0]      wr_data_o,
    output logic            busy_o
);
    // Fastest host bit time vs. our clock, kept for reference
    localparam int CIS_CYC_PER_BIT = (CIS_CLK_MHZ * 1000) / CIS_HS_KHZ;

    typedef struct packed {
        cis_state_e state;
        cis_byte_e  kind;
        logic [7:0] shift;
        logic [2:0] bitn;
        logic [7:0] ptr;
        logic       rd;
        logic       drive_low;
        logic       wr;
        logic [7:0] wdata;
        logic       ack_ok;
    } cis_st_s;

    cis_st_s st_r;
    cis_st_s st_nxt;

    logic [7:0] map_r [CIS_MAP_DEPTH];
    logic       scl_l;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_l;
    logic       sda_rise;
    logic       sda_fall;
    logic       start_c;
    logic       stop_c;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;
    logic [7:0] tx_next;
    logic [7:0] ptr_inc;

    cis_sync u_scl (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (scl_i),
        .lvl_o  (scl_l),
        .rise_o (scl_rise),
        .fall_o (scl_fall)
    );

    cis_sync u_sda (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (sda_i),
        .lvl_o  (sda_l),
        .rise_o (sda_rise),
        .fall_o (sda_fall)
    );

    assign start_c  = sda_fall & scl_l;
    assign stop_c   = sda_rise & scl_l;
    assign own_addr = CIS_ADDR_BASE | {5'h00, addr_cfg_i};
    // Full 8-bit space is mapped; the zero path covers any narrower map
    assign rd_byte  = (st_r.ptr <= CIS_MAP_LAST) ? map_r[st_r.ptr] : CIS_READ_ZERO;
    assign ptr_inc  = (write_mode_i == CIS_MODE_PAGE) ? st_r.ptr + 8'h01 : st_r.ptr;
    assign tx_next  = (ptr_inc <= CIS_MAP_LAST) ? map_r[ptr_inc] : CIS_READ_ZERO;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.wr = 1'b0;
        if (!enable_i) begin
            st_nxt.state     = CIS_IDLE;
            st_nxt.drive_low = 1'b0;
        end else if (start_c) begin
            // Repeated START keeps the pointer for a following read
            st_nxt.state     = CIS_RX;
            st_nxt.kind      = CIS_BYTE_DEV;
            st_nxt.bitn      = CIS_BIT_FIRST;
            st_nxt.ack_ok    = 1'b0;
            st_nxt.drive_low = 1'b0;
        end else if (stop_c) begin
            st_nxt.state     = CIS_IDLE;
            st_nxt.ack_ok    = 1'b0;
            st_nxt.drive_low = 1'b0;
        end else begin
            case (st_r.state)
                CIS_IDLE, CIS_IGNORE: begin
                    st_nxt.drive_low = 1'b0;
                end
                CIS_RX: begin
                    if (scl_rise) begin
                        st_nxt.shift = {st_r.shift[6:0], sda_l};
                        st_nxt.bitn  = st_r.bitn + 3'h1;
                        if (st_r.bitn == CIS_BIT_LAST) begin
                            // Eighth bit in; judge the byte in the low phase
                            st_nxt.ack_ok = 1'b1;
                        end
                    end
                    if (scl_fall && st_r.ack_ok && st_r.bitn == CIS_BIT_FIRST) begin
                        case (st_r.kind)
                            CIS_BYTE_DEV: begin
                                if (st_r.shift[7:1] == own_addr) begin
                                    st_nxt.rd        = (st_r.shift[0] == CIS_RW_READ);
                                    st_nxt.state     = CIS_RX_ACK;
                                    st_nxt.drive_low = 1'b1;
                                end else begin
                                    st_nxt.state = CIS_IGNORE;
                                end
                            end
                            CIS_BYTE_REG: begin
                                st_nxt.ptr       = st_r.shift;
                                st_nxt.state     = CIS_RX_ACK;
                                st_nxt.drive_low = 1'b1;
                            end
                            CIS_BYTE_DATA: begin
                                st_nxt.wr        = 1'b1;
                                st_nxt.wdata     = st_r.shift;
                                st_nxt.state     = CIS_RX_ACK;
                                st_nxt.drive_low = 1'b1;
                            end
                            default: st_nxt.state = CIS_IGNORE;
                        endcase
                    end
                end
                CIS_RX_ACK: begin
                    // At end of the ninth clock release, or drive the first read bit after a read address
                    if (scl_fall) begin
                        st_nxt.bitn   = CIS_BIT_FIRST;
                        st_nxt.ack_ok = 1'b0;
                        if (st_r.kind == CIS_BYTE_DEV && st_r.rd) begin
                            st_nxt.state     = CIS_TX;
                            st_nxt.shift     = rd_byte;
                            st_nxt.drive_low = ~rd_byte[7];
                        end else begin
                            st_nxt.state     = CIS_RX;
                            st_nxt.drive_low = 1'b0;
                            if (st_r.kind == CIS_BYTE_DEV) begin
                                st_nxt.kind = CIS_BYTE_REG;
                            end else if (st_r.kind == CIS_BYTE_REG) begin
                                st_nxt.kind = CIS_BYTE_DATA;
                            end else begin
                                st_nxt.ptr = ptr_inc;
                            end
                        end
                    end
                end
                CIS_TX: begin
                    if (scl_fall) begin
                        st_nxt.bitn = st_r.bitn + 3'h1;
                        if (st_r.bitn == CIS_BIT_LAST) begin
                            st_nxt.state     = CIS_TX_ACK;
                            st_nxt.drive_low = 1'b0;
                        end else begin
                            st_nxt.shift     = {st_r.shift[6:0], 1'b0};
                            st_nxt.drive_low = ~st_r.shift[6];
                        end
                    end
                end
                CIS_TX_ACK: begin
                    if (scl_rise) begin
                        st_nxt.ack_ok = ~sda_l;
                    end
                    if (scl_fall) begin
                        if (st_r.ack_ok) begin
                            st_nxt.ptr       = ptr_inc;
                            st_nxt.shift     = tx_next;
                            st_nxt.bitn      = CIS_BIT_FIRST;
                            st_nxt.state     = CIS_TX;
                            st_nxt.drive_low = ~tx_next[7];
                        end else begin
                            st_nxt.state = CIS_IGNORE;
                        end
                    end
                end
                default: begin
                    st_nxt.state     = CIS_IDLE;
                    st_nxt.drive_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{state: CIS_IDLE, kind: CIS_BYTE_DEV, shift: 8'h00, bitn: 3'h0,
                      ptr: 8'h00, rd: 1'b0, drive_low: 1'b0, wr: 1'b0, wdata: 8'h00,
                      ack_ok: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Register map storage
    generate
        for (genvar i = 0; i < CIS_MAP_DEPTH; i++) begin : g_map
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    map_r[i] <= CIS_MAP_RST;
                end else if (st_r.wr && st_r.ptr == 8'(i)) begin
                    map_r[i] <= st_r.wdata;
                end
            end
        end
    endgenerate

    // Open drain: only ever pulls low, never clocks the bus
    assign sda_o      = 1'b0;
    assign sda_oe_o   = st_r.drive_low;
    assign reg_addr_o = st_r.ptr;
    assign wr_pulse_o = st_r.wr;
    assign wr_data_o  = st_r.wdata;
    assign busy_o     = (st_r.state != CIS_IDLE) && (st_r.state != CIS_IGNORE);

    ack_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_RX && st_r.kind == CIS_BYTE_DEV && scl_fall && st_r.ack_ok
         && st_r.bitn == 3'h0 && st_r.shift[7:1] == own_addr && enable_i && !start_c && !stop_c)
        |=> sda_oe_o)
        else $error("own address not acknowledged");
    foreign_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.state == CIS_IGNORE |-> !sda_oe_o)
        else $error("drives bus while ignoring");
    stop_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (stop_c && !start_c && enable_i) |=> st_r.state == CIS_IDLE && !sda_oe_o)
        else $error("stop did not idle");
    start_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_c && enable_i) |=> st_r.state == CIS_RX && st_r.kind == CIS_BYTE_DEV)
        else $error("start not taken");
    never_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sda_o == 1'b0)
        else $error("data driven high");
    repeat_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (write_mode_i && st_r.state == CIS_TX_ACK && scl_fall && enable_i && !start_c
         && !stop_c) |=> $stable(st_r.ptr))
        else $error("repeat mode advanced pointer");
    page_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!write_mode_i && st_r.state == CIS_TX_ACK && st_r.ack_ok && scl_fall && enable_i
         && !start_c && !stop_c) |=> st_r.ptr == $past(st_r.ptr) + 8'h01)
        else $error("page read did not advance");
    write_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pulse_o |=> map_r[$past(reg_addr_o)] == $past(wr_data_o))
        else $error("write not stored");
    disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !enable_i |=> !sda_oe_o)
        else $error("active while disabled");

    // Byte level checks
    own_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        own_addr == CIS_ADDR_BASE + {5'h00, addr_cfg_i})
        else $error("bus address select wrong");
    ack_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.state == CIS_RX_ACK |-> sda_oe_o)
        else $error("acknowledge not held");
    ack_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_RX_ACK && !(st_r.kind == CIS_BYTE_DEV && st_r.rd) && scl_fall
         && enable_i && !start_c && !stop_c)
        |=> !sda_oe_o)
        else $error("acknowledge not released");
    reg_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_RX && st_r.kind == CIS_BYTE_REG && st_r.ack_ok && scl_fall
         && st_r.bitn == 3'h0 && enable_i && !start_c && !stop_c)
        |=> reg_addr_o == $past(st_r.shift))
        else $error("register address not taken");
    wr_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pulse_o |=> !wr_pulse_o)
        else $error("write pulse too long");
    page_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!write_mode_i && st_r.state == CIS_RX_ACK && st_r.kind == CIS_BYTE_DATA && scl_fall
         && enable_i && !start_c && !stop_c)
        |=> st_r.ptr == $past(st_r.ptr) + 8'h01)
        else $error("page write did not advance");
    repeat_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (write_mode_i && st_r.state == CIS_RX_ACK && st_r.kind == CIS_BYTE_DATA && scl_fall
         && enable_i && !start_c && !stop_c)
        |=> $stable(st_r.ptr))
        else $error("repeat write advanced pointer");
    tx_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_RX_ACK && st_r.kind == CIS_BYTE_DEV && st_r.rd && scl_fall
         && enable_i && !start_c && !stop_c)
        |=> sda_oe_o == !$past(rd_byte[7]))
        else $error("first read bit wrong");
    tx_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_TX && st_r.bitn != CIS_BIT_LAST && scl_fall
         && enable_i && !start_c && !stop_c)
        |=> sda_oe_o == !$past(st_r.shift[6]))
        else $error("read bit out of order");
    tx_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.state == CIS_TX_ACK |-> !sda_oe_o)
        else $error("host acknowledge slot driven");
    drive_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_i && !start_c && !stop_c && !scl_fall) |=> $stable(sda_oe_o))
        else $error("data changed outside low phase");
    nak_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_TX_ACK && !st_r.ack_ok && scl_fall && enable_i && !start_c
         && !stop_c) |=> st_r.state == CIS_IGNORE)
        else $error("host refusal not honoured");
    start_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_c && enable_i) |=> !sda_oe_o)
        else $error("start did not release data");
    start_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_c && enable_i) |=> $stable(st_r.ptr))
        else $error("start moved pointer");
    ignore_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == CIS_IGNORE && enable_i && !start_c && !stop_c)
        |=> st_r.state == CIS_IGNORE)
        else $error("left ignore without start");
endmodule
`default_nettype wire

/* bench/cis_host_model.sv */
// Behavioural two-wire bus master that drives the control slave.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module cis_host_model
    import cis_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Host owns SCL, 8 clk per phase, stands high between frames
    task automatic start_cond();
        sda_oe_o = 1'b0;
        tick(6);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b1; // Fall while SCL high
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask

    task automatic stop_cond();
        sda_oe_o = 1'b1;
        tick(6);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b0; // Rise while SCL high
        tick(8);
    endtask

    task automatic bit_xfer(input logic b, output logic r);
        sda_oe_o = ~b; // Only pull low or release, change while SCL low
        tick(6);
        scl_o = 1'b1;
        tick(4);
        r = sda_i;
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask

    task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r[i]); // MSB first
        bit_xfer(ack_in, ack);
    endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the two-wire control slave.
// Assumes the host model as bus master and a pull-up on the data wire.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cis_pkg::*;
    logic       clk = 1'b0;
    logic       rst;
    logic       enable;
    logic [1:0] addr_cfg;
    logic       write_mode;
    logic       scl;
    logic       host_oe;
    logic       sda_out;
    logic       sda_oe;
    logic       busy;
    logic       sda;
    logic [7:0] reg_addr;
    logic       wr_pulse;
    logic [7:0] wr_data;
    logic [7:0] wr_count = 8'h00;
    logic [7:0] last_wr_addr = 8'h00;
    logic [7:0] last_wr_data = 8'h00;
    int         err_count = 0;
    int         checks = 0;

    assign sda = ~(host_oe | (sda_oe & ~sda_out));

    always #5 clk = ~clk;

    cis_slave cis_slave_i (
        .clk_i(clk), .rst_i(rst), .enable_i(enable), .addr_cfg_i(addr_cfg),
        .write_mode_i(write_mode), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
        .sda_oe_o(sda_oe), .reg_addr_o(reg_addr), .wr_pulse_o(wr_pulse), .wr_data_o(wr_data),
        .busy_o(busy)
    );

    // Record what the slave hands to its register map
    always @(posedge clk) begin
        if (wr_pulse) begin
            wr_count     <= wr_count + 8'h01;
            last_wr_addr <= reg_addr;
            last_wr_data <= wr_data;
        end
    end

    cis_host_model cis_host_model_i (
        .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic addr(input logic [6:0] dev, input logic rw, output logic ack);
        logic [7:0] r;
        cis_host_model_i.start_cond();
        cis_host_model_i.byte_xfer({dev, rw}, 1'b1, r, ack);
    endtask

    task automatic put(input logic [7:0] d, output logic ack);
        logic [7:0] r;
        cis_host_model_i.byte_xfer(d, 1'b1, r, ack);
    endtask

    task automatic get(input logic last, output logic [7:0] d);
        logic a;
        cis_host_model_i.byte_xfer(8'hff, last, d, a);
    endtask

    // Set pointer, then same address again after repeated START
    task automatic point(input logic [7:0] ra);
        logic a;
        addr(7'h1a, 1'b0, a);
        put(ra, a);
        addr(7'h1a, 1'b1, a);
    endtask

    task automatic t_addr();
        logic ack;
        for (int c = 0; c < 4; c++) begin
            addr_cfg = c[1:0];
            addr(7'h18 + 7'(c), 1'b0, ack);
            check("own address ack", {7'h0, ack}, 8'h00);
            cis_host_model_i.stop_cond();
            addr(7'h18 + 7'(c ^ 1), 1'b0, ack);
            check("foreign address nak", {7'h0, ack}, 8'h01);
            put(8'h00, ack);
            check("foreign byte nak", {7'h0, ack}, 8'h01);
            cis_host_model_i.stop_cond();
        end
        addr_cfg = 2'h2;
        enable = 1'b0;
        addr(7'h1a, 1'b0, ack);
        check("disabled nak", {7'h0, ack}, 8'h01);
        cis_host_model_i.stop_cond();
        enable = 1'b1;
    endtask

    task automatic t_page();
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        logic [7:0] d;
        addr(7'h1a, 1'b0, a0);
        put(8'hfe, a1);
        put(8'h5a, a2);
        put(8'hc3, a3);
        check("write acks", {4'h0, a0, a1, a2, a3}, 8'h00);
        cis_host_model_i.stop_cond();
        check("write count", wr_count, 8'h02);
        check("write address", last_wr_addr, 8'hff);
        check("write data", last_wr_data, 8'hc3);
        check("idle after stop", {7'h0, busy}, 8'h00);
        point(8'hfe);
        get(1'b0, d);
        check("page read first", d, 8'h5a);
        get(1'b1, d);
        check("page read next", d, 8'hc3);
        cis_host_model_i.stop_cond();
        point(8'h40);
        get(1'b1, d);
        check("unwritten reads zero", d, 8'h00);
        cis_host_model_i.stop_cond();
    endtask

    task automatic t_repeat();
        logic       a;
        logic [7:0] d;
        write_mode = 1'b1;
        addr(7'h1a, 1'b0, a);
        put(8'h20, a);
        put(8'h11, a);
        put(8'h22, a);
        cis_host_model_i.stop_cond();
        check("repeat write count", wr_count, 8'h04);
        check("repeat write address", last_wr_addr, 8'h20);
        point(8'h20);
        get(1'b0, d);
        check("repeat write last", d, 8'h22);
        get(1'b1, d);
        check("repeat read same", d, 8'h22);
        cis_host_model_i.stop_cond();
        point(8'h21);
        get(1'b1, d);
        check("repeat no advance", d, 8'h00);
        cis_host_model_i.stop_cond();
        write_mode = 1'b0;
    endtask

    task automatic final_report();
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst        = 1'b1;
        enable     = 1'b1;
        addr_cfg   = 2'h2;
        write_mode = 1'b0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_addr();
        t_page();
        t_repeat();
        final_report();
    end

    // About 6.2k clk of traffic expected; cut off well beyond that
    initial begin
        #400000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
